/* File: rtl/bsel_boot_select.sv */
/*
 * Boot mode selector: samples the boot straps after reset, decodes the
 * boot mode, drives the boot memory chip select in EPROM mode and
 * starts execution at the reset vector.
 * Assumes straps are static board straps, reset is held at power-up
 * and the input clock runs continuously.
 */
// Operation
// - EPROM high, link low: 8-bit EPROM boot
// - EPROM mode: memory select is chip-select output
// - EPROM low: link and memory select choose
// - Straps 001 select host processor boot
// - Straps 011 select link port boot
// - Straps 000: no boot, run external memory
// - Select pin is driven only in EPROM mode
// - Only shared bus owner drives select output
// - One instruction per input clock period
// - Reset gives known state, start at vector
`timescale 1ns/10ps
module bsel_boot_select #(
    parameter logic [bsel_pkg::ADDR_W-1:0] VECTOR = bsel_pkg::RESET_VECTOR
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic eprom_boot_select_in,
    input wire logic link_boot_select_in,
    input wire logic boot_memory_select_n_in,
    input wire logic bus_owner_in,
    input wire logic boot_cs_req_in,
    input wire logic float_req_in,
    output logic boot_memory_select_n_out,
    output logic boot_memory_select_n_oe_out,
    output bsel_pkg::bsel_mode_t boot_mode_out,
    output logic boot_mode_valid_out,
    output logic eprom_width8_out,
    output logic strap_reserved_out,
    output logic exec_start_out,
    output logic [bsel_pkg::ADDR_W-1:0] exec_addr_out,
    output logic instr_tick_out
);

    // ==========================================================
    // Strap synchronisers
    // ==========================================================
    logic [bsel_pkg::STRAP_W-1:0] strap_raw;
    logic [bsel_pkg::STRAP_W-1:0] strap_sync;

    assign strap_raw = {eprom_boot_select_in, link_boot_select_in,
                        boot_memory_select_n_in};

    bsel_sync #(
        .WIDTH(bsel_pkg::STRAP_W),
        .RESET_VAL(bsel_pkg::STRAP_RESET)
    ) u_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .async_in(strap_raw),
        .sync_out(strap_sync)
    );

    // ==========================================================
    // Strap decode
    // ==========================================================
    bsel_pkg::bsel_mode_t mode_d;
    logic reserved_d;

    always_comb begin
        mode_d = bsel_pkg::MODE_NONE;
        reserved_d = 1'b0;
        if (strap_sync[bsel_pkg::STRAP_EPROM]) begin
            mode_d = bsel_pkg::MODE_EPROM;
            reserved_d = strap_sync[bsel_pkg::STRAP_LINK];
        end else begin
            unique case ({strap_sync[bsel_pkg::STRAP_LINK],
                          strap_sync[bsel_pkg::STRAP_MEMSEL]})
                2'h0: mode_d = bsel_pkg::MODE_NONE;
                2'h1: mode_d = bsel_pkg::MODE_HOST;
                // Reserved 010, treated as no boot
                2'h2: begin
                    mode_d = bsel_pkg::MODE_NONE;
                    reserved_d = 1'b1;
                end
                2'h3: mode_d = bsel_pkg::MODE_LINK;
            endcase
        end
    end

    // ==========================================================
    // Reset sequencer
    // ==========================================================
    // Settling waits out the sync chain so the captured straps are
    // the post-reset levels, not the reset value of the flops.
    bsel_pkg::bsel_state_t state_q;
    logic [bsel_pkg::CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= bsel_pkg::ST_HOLD;
        end else begin
            unique case (state_q)
                bsel_pkg::ST_HOLD: state_q <= bsel_pkg::ST_SETTLE;
                bsel_pkg::ST_SETTLE: begin
                    if (cnt_q == bsel_pkg::CNT_LAST) begin
                        state_q <= bsel_pkg::ST_START;
                    end
                end
                bsel_pkg::ST_START: state_q <= bsel_pkg::ST_RUN;
                bsel_pkg::ST_RUN: state_q <= bsel_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= bsel_pkg::CNT_RESET;
        end else if (state_q == bsel_pkg::ST_SETTLE) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // ==========================================================
    // Boot mode capture
    // ==========================================================
    bsel_pkg::bsel_mode_t mode_q;
    logic valid_q;
    logic reserved_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_q <= bsel_pkg::MODE_NONE;
            valid_q <= 1'b0;
            reserved_q <= 1'b0;
        end else if (state_q == bsel_pkg::ST_SETTLE &&
                     cnt_q == bsel_pkg::CNT_LAST) begin
            mode_q <= mode_d;
            valid_q <= 1'b1;
            reserved_q <= reserved_d;
        end
    end

    assign boot_mode_out = mode_q;
    assign boot_mode_valid_out = valid_q;
    assign strap_reserved_out = reserved_q;
    assign eprom_width8_out = valid_q && mode_q == bsel_pkg::MODE_EPROM;

    // ==========================================================
    // Execution start
    // ==========================================================
    logic start_q;
    logic tick_q;
    logic [bsel_pkg::ADDR_W-1:0] addr_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_q <= 1'b0;
            addr_q <= '0;
        end else begin
            start_q <= state_q == bsel_pkg::ST_START;
            if (state_q == bsel_pkg::ST_START) begin
                addr_q <= VECTOR;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= state_q == bsel_pkg::ST_START ||
                      state_q == bsel_pkg::ST_RUN;
        end
    end

    assign exec_start_out = start_q;
    assign exec_addr_out = addr_q;
    assign instr_tick_out = tick_q;

    // ==========================================================
    // Boot memory select pin
    // ==========================================================
    // Outside EPROM mode the pin is a strap input and never driven,
    // so a float request there has nothing to act on.
    logic cs_n_q;
    logic oe_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cs_n_q <= bsel_pkg::PIN_IDLE;
            oe_q <= 1'b0;
        end else begin
            cs_n_q <= !(boot_cs_req_in && bus_owner_in);
            oe_q <= valid_q && mode_q == bsel_pkg::MODE_EPROM &&
                    bus_owner_in && !float_req_in;
        end
    end

    assign boot_memory_select_n_out = cs_n_q;
    assign boot_memory_select_n_oe_out = oe_q;

    // ==========================================================
    // Checks
    // ==========================================================
    // Capture edge qualified by a strap condition
    sequence s_settle_done(cond);
        state_q == bsel_pkg::ST_SETTLE && cnt_q == bsel_pkg::CNT_LAST &&
        cond;
    endsequence

    sequence s_started;
        exec_start_out && exec_addr_out == VECTOR;
    endsequence

    a_eprom_mode_decode: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        s_settle_done(strap_sync[bsel_pkg::STRAP_EPROM])
        |=> boot_mode_out == bsel_pkg::MODE_EPROM)
        else $error("EPROM strap not decoded");

    a_cs_drive_eprom: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        boot_mode_valid_out && boot_mode_out == bsel_pkg::MODE_EPROM &&
        bus_owner_in && !float_req_in && boot_cs_req_in
        |=> boot_memory_select_n_oe_out && !boot_memory_select_n_out)
        else $error("Chip select not asserted");

    a_host_mode_decode: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        s_settle_done(strap_sync == 3'h1)
        |=> boot_mode_out == bsel_pkg::MODE_HOST)
        else $error("Host strap not decoded");

    a_link_mode_decode: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        s_settle_done(strap_sync == 3'h3)
        |=> boot_mode_out == bsel_pkg::MODE_LINK)
        else $error("Link strap not decoded");

    a_none_mode_decode: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        s_settle_done(strap_sync == 3'h0)
        |=> boot_mode_out == bsel_pkg::MODE_NONE && !strap_reserved_out)
        else $error("No-boot strap not decoded");

    a_pin_input_else: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        boot_memory_select_n_oe_out |->
        $past(boot_mode_out) == bsel_pkg::MODE_EPROM &&
        $past(boot_mode_valid_out))
        else $error("Select pin driven outside EPROM mode");

    a_owner_only_drive: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        !bus_owner_in |=> !boot_memory_select_n_oe_out)
        else $error("Select pin driven without bus ownership");

    a_tick_every_cycle: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        s_started |-> instr_tick_out [*8])
        else $error("Instruction tick missed");

    a_start_at_vector: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        $rose(boot_mode_valid_out) |=> s_started ##1 !exec_start_out)
        else $error("Start pulse or vector wrong");

    a_mode_held: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        boot_mode_valid_out |=> boot_mode_valid_out &&
        $stable(boot_mode_out) && $stable(strap_reserved_out))
        else $error("Boot mode changed before reset");

endmodule // bsel_boot_select

/* File: rtl/bsel_pkg.sv */
/*
 * Constants and types shared by the boot mode selector.
 * Assumes one clock domain and an asynchronous active-low reset.
 */
package bsel_pkg;

    // ==========================================================
    // Strap sampling
    // ==========================================================
    localparam int unsigned SYNC_STAGES = 2;
    // Sync stages plus one guard cycle before the straps are taken
    localparam int unsigned SETTLE_CYCLES = SYNC_STAGES + 1;
    localparam int unsigned CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);

    // ==========================================================
    // Strap positions in the packed strap word
    // ==========================================================
    localparam int unsigned STRAP_W = 3;
    localparam int unsigned STRAP_EPROM = 2;
    localparam int unsigned STRAP_LINK = 1;
    localparam int unsigned STRAP_MEMSEL = 0;
    localparam logic [STRAP_W-1:0] STRAP_RESET = 3'h1;

    // ==========================================================
    // Reset vector and pin reset levels
    // ==========================================================
    localparam int unsigned ADDR_W = 24;
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 24'h020004;
    localparam logic PIN_IDLE = 1'h1;

    // ==========================================================
    // Boot modes and sequencer states
    // ==========================================================
    typedef enum logic [1:0] {
        MODE_EPROM = 2'h0,
        MODE_HOST = 2'h1,
        MODE_LINK = 2'h2,
        MODE_NONE = 2'h3
    } bsel_mode_t;

    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_SETTLE = 2'h1,
        ST_START = 2'h2,
        ST_RUN = 2'h3
    } bsel_state_t;

endpackage

/* File: rtl/bsel_sync.sv */
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes inputs arrive from outside the clock domain.
 */
`timescale 1ns/10ps
module bsel_sync #(
    parameter int unsigned WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Per-bit chains
    // ==========================================================
    // First stage feeds only the second stage
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_q;
        logic stable_q;
        always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                meta_q <= RESET_VAL[i];
                stable_q <= RESET_VAL[i];
            end else begin
                meta_q <= async_in[i];
                stable_q <= meta_q;
            end
        end
        assign sync_out[i] = stable_q;
    end

endmodule // bsel_sync

/* File: verification/bsel_board_model.sv */
/*
 * Board-side partner: strap resistors and the boot memory select wire.
 * Assumes the bench changes strap levels while reset is held, apart from the hold_after_boot check.
 */
`timescale 1ns/10ps
module bsel_board_model (
    input wire logic [2:0] strap_in,
    input wire logic pin_out_in,
    input wire logic pin_oe_in,
    output logic eprom_out,
    output logic link_out,
    output logic pin_wire_out
);
    // ==========================================================
    // Straps and select wire
    // ==========================================================
    // fixed board straps
    assign eprom_out = strap_in[bsel_pkg::STRAP_EPROM];
    assign link_out = strap_in[bsel_pkg::STRAP_LINK];
    // driver wins over strap
    // A released pin falls back to its strap resistor, never the last level
    assign pin_wire_out = pin_oe_in ? pin_out_in
                                    : strap_in[bsel_pkg::STRAP_MEMSEL];
endmodule // bsel_board_model

/* File: verification/tb.sv */
/*
 * Self-checking bench for the boot mode selector.
 * Assumes the package constants and a board model for straps and pin.
 */
`timescale 1ns/10ps
module tb;
    logic clk_in = 1'b0;
    // Test logic shares this held-low power-up reset
    logic arst_n_in = 1'b0;
    logic [2:0] strap = 3'h1;
    logic bus_owner_in = 1'b0;
    logic boot_cs_req_in = 1'b0;
    logic float_req_in = 1'b0;
    logic eprom_w, link_w, pin_w, cs_n_w, oe_w, valid_w, w8_w, resv_w;
    logic start_w, tick_w;
    bsel_pkg::bsel_mode_t mode_w;
    logic [bsel_pkg::ADDR_W-1:0] addr_w;
    int err_total = 0;
    int checks = 0;

    // ==========================================================
    // Clock, board and design
    // ==========================================================
    // Free-running clock, never halted
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    bsel_board_model board (.strap_in(strap), .pin_out_in(cs_n_w),
        .pin_oe_in(oe_w), .eprom_out(eprom_w), .link_out(link_w),
        .pin_wire_out(pin_w));

    bsel_boot_select dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .eprom_boot_select_in(eprom_w), .link_boot_select_in(link_w),
        .boot_memory_select_n_in(pin_w), .bus_owner_in(bus_owner_in),
        .boot_cs_req_in(boot_cs_req_in), .float_req_in(float_req_in),
        .boot_memory_select_n_out(cs_n_w),
        .boot_memory_select_n_oe_out(oe_w), .boot_mode_out(mode_w),
        .boot_mode_valid_out(valid_w), .eprom_width8_out(w8_w),
        .strap_reserved_out(resv_w), .exec_start_out(start_w),
        .exec_addr_out(addr_w), .instr_tick_out(tick_w));

    // ==========================================================
    // Report and compare
    // ==========================================================
    task automatic stop_test();
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp,
        input logic got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %b seen %b", what, exp, got);
            err_total++;
        end
    endtask

    task automatic chk_mode(input string what,
        input bsel_pkg::bsel_mode_t exp, input bsel_pkg::bsel_mode_t got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic chk_addr(input string what,
        input logic [bsel_pkg::ADDR_W-1:0] exp,
        input logic [bsel_pkg::ADDR_W-1:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // do_reset moves the straps inside reset, as a hardwired board would show
    task automatic do_reset(input logic [2:0] s);
        @(negedge clk_in);
        arst_n_in = 1'b0;
        strap = s;
        repeat (2) @(negedge clk_in);
        chk_mode("reset mode", bsel_pkg::MODE_NONE, mode_w);
        chk_bit("reset valid", 1'b0, valid_w);
        chk_bit("reset oe", 1'b0, oe_w);
        chk_bit("reset cs_n", 1'b1, cs_n_w);
        chk_addr("reset addr", '0, addr_w);
        chk_bit("reset tick", 1'b0, tick_w);
        arst_n_in = 1'b1;
    endtask

    task automatic boot_case(input logic [2:0] s);
        bsel_pkg::bsel_mode_t em;
        logic er;
        int n;
        em = s[2] ? bsel_pkg::MODE_EPROM
           : (s[1:0] == 2'h1) ? bsel_pkg::MODE_HOST
           : (s[1:0] == 2'h3) ? bsel_pkg::MODE_LINK : bsel_pkg::MODE_NONE;
        er = s[2] ? s[1] : (s[1:0] == 2'h2);
        do_reset(s);
        n = 0;
        while (valid_w !== 1'b1) begin
            n++;
            if (n > 10) begin
                err_total++;
                stop_test();
            end
            @(negedge clk_in);
        end
        chk_mode("mode", em, mode_w);
        chk_bit("reserved", er, resv_w);
        chk_bit("width8", s[2], w8_w);
        @(negedge clk_in);
        chk_bit("start", 1'b1, start_w);
        chk_addr("addr", bsel_pkg::RESET_VECTOR, addr_w);
        repeat (3) begin
            @(negedge clk_in);
            chk_bit("start off", 1'b0, start_w);
            chk_bit("tick", 1'b1, tick_w);
        end
    endtask

    task automatic hold_after_boot();
        boot_case(3'h1);
        strap = 3'h3;
        repeat (6) @(negedge clk_in);
        chk_mode("kept mode", bsel_pkg::MODE_HOST, mode_w);
        chk_bit("host oe", 1'b0, oe_w);
    endtask

    task automatic pin_case(input logic [2:0] s);
        logic oe_exp;
        logic cs_exp;
        boot_case(s);
        for (int i = 0; i < 8; i++) begin
            {bus_owner_in, boot_cs_req_in, float_req_in} = 3'(i);
            @(negedge clk_in);
            oe_exp = s[2] & bus_owner_in & ~float_req_in;
            cs_exp = ~(boot_cs_req_in & bus_owner_in);
            chk_bit("oe", oe_exp, oe_w);
            chk_bit("cs_n", cs_exp, cs_n_w);
            // Driven pin carries the select, released pin its strap
            if (oe_exp) begin
                chk_bit("wire", cs_exp, pin_w);
            end else begin
                chk_bit("wire", s[0], pin_w);
            end
        end
        {bus_owner_in, boot_cs_req_in, float_req_in} = 3'h0;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        for (int i = 0; i < 8; i++) begin
            boot_case(3'(i));
        end
        hold_after_boot();
        pin_case(3'h4);
        pin_case(3'h3);
        stop_test();
    end
endmodule // tb
